// ---- rtl/drive_chan_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef DRIVE_CHAN_CONSTS_SVH
`define DRIVE_CHAN_CONSTS_SVH

`define CLK_PERIOD_NS     20
`define MS_TIME_NS        1000000
`define CHAR_TIME_NS      1146000
`define CHAR_CYCLES       (`CHAR_TIME_NS / `CLK_PERIOD_NS)
`define RESP_DELAY_RST    32'(3 * `CHAR_CYCLES)
`define LIMIT_RST         16'h0064
`define PD_LEN_RST        4'h4
`define CHAN_WORDS        4'h4
`define RX_WORDS          4'h8
`define PD_CTRL2_MIN_LEN  4'h4
`define CTRL1_REQ_BIT     10
`define DRIVE_OBJECT      6'h3f

`define OFS_CTRL          8'h00
`define OFS_LIMIT         8'h04
`define OFS_DELAY         8'h08
`define OFS_STATUS        8'h0c
`define OFS_REQ           8'h10
`define OFS_VALUE         8'h14
`define OFS_CONN          8'h18
`define OFS_PD_IN         8'h1c
`define OFS_PD_IN2        8'h20
`define OFS_PD_OUT        8'h24

`define AK_READ_ARRAY     4'h6
`define AK_WRITE_ARRAY    4'h7
`define RESP_ERROR        4'h7
`define RESP_ACK          4'h1
`define ERR_BAD_NUMBER    16'h0000
`define ERR_NOT_SUPPORTED 16'h006a

`define PAGE_0     8'h00
`define PAGE_2000  8'h80
`define PAGE_6000  8'h90
`define PAGE_8000  8'h20
`define PAGE_10000 8'ha0
`define PAGE_20000 8'h50
`define PAGE_30000 8'hf0
`define PAGE_60000 8'h74
`define OFFSET_0     16'd0
`define OFFSET_2000  16'd2000
`define OFFSET_6000  16'd6000
`define OFFSET_8000  16'd8000
`define OFFSET_10000 16'd10000
`define OFFSET_20000 16'd20000
`define OFFSET_30000 16'd30000
`define OFFSET_60000 16'd60000

`endif

// ---- rtl/drive_chan_pkg.sv ----
// state types of the parameter channel slave and its request timer
package drive_chan_pkg;

   typedef enum logic [1:0] {
      T_IDLE = 2'b01,
      T_WAIT = 2'b10
   } timer_state_t;

   typedef struct packed {
      timer_state_t state;
      logic [15:0]  ms_div;
      logic [15:0]  ms_count;
      logic         expired;
      logic [31:0]  delay_cnt;
      logic         timeout;
      logic         resp_go;
   } timer_regs_t;

   typedef struct packed {
      logic             wr_pend;
      logic [7:0]       waddr;
      logic             hreadyout;
      logic [31:0]      hrdata;
      logic [3:0]       pd_len;
      logic [15:0]      limit_ms;
      logic [31:0]      resp_delay;
      logic [7:0][15:0] rxw;
      logic [3:0]       wcount;
      logic [3:0]       req_id;
      logic [15:0]      full_num;
      logic [7:0]       subindex;
      logic [31:0]      value;
      logic [15:0]      conn_src;
      logic [5:0]       conn_obj;
      logic [9:0]       conn_idx;
      logic [15:0]      ctrl1;
      logic [15:0]      setpoint;
      logic [15:0]      ctrl2;
      logic [15:0]      status_word;
      logic [15:0]      actual_value;
      logic             fail;
      logic             missing;
      logic             err;
      logic [3:0]       resp_id;
      logic [15:0]      resp_error;
      logic             resp_start;
      logic             req_done;
      logic             run_meta;
      logic             run_sync;
   } chan_regs_t;

endpackage

// ---- rtl/timer_if.sv ----
// signals between the channel decoder and its request timer
`timescale 1ns/100ps
interface timer_if;
   logic [15:0] limit_ms;
   logic [31:0] resp_delay;
   logic        req_done;
   logic        timeout;
   logic        resp_go;
   modport chan  (output limit_ms, resp_delay, req_done, input timeout, resp_go);
   modport timer (input limit_ms, resp_delay, req_done, output timeout, resp_go);
endinterface

// ---- rtl/request_timer.sv ----
// request interval monitor and response delay timer
`timescale 1ns/100ps
`include "drive_chan_consts.svh"

module request_timer
   import drive_chan_pkg::*;
#(
   parameter int MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   timer_if.timer    tif
);

   timer_regs_t t;
   timer_regs_t next_t;
   logic        tick;

   assign tif.timeout = t.timeout;
   assign tif.resp_go = t.resp_go;

   always_comb begin
      next_t         = t;
      next_t.timeout = 1'b0;
      next_t.resp_go = 1'b0;
      tick           = (t.ms_div == 16'(MS_CYCLES - 1));
      next_t.ms_div  = tick ? 16'h0000 : t.ms_div + 16'h0001;
      // (R16) interval check
      if (tif.limit_ms == 16'h0000) begin
         next_t.ms_count = 16'h0000;
         next_t.expired  = 1'b0;
      end else if (tick && !t.expired) begin
         if (t.ms_count >= tif.limit_ms) begin
            next_t.timeout = 1'b1;
            next_t.expired = 1'b1;
         end else begin
            next_t.ms_count = t.ms_count + 16'h0001;
         end
      end
      // (R21) restart on request
      if (tif.req_done) begin
         next_t.ms_div   = 16'h0000;
         next_t.ms_count = 16'h0000;
         next_t.expired  = 1'b0;
      end
      // (R13) hold off response
      case (t.state)
         T_IDLE: begin
            if (tif.req_done) begin
               next_t.state     = T_WAIT;
               next_t.delay_cnt = tif.resp_delay;
            end
         end
         T_WAIT: begin
            if (tif.req_done) begin
               next_t.delay_cnt = tif.resp_delay;
            end else if (t.delay_cnt <= 32'h1) begin
               next_t.resp_go = 1'b1;
               next_t.state   = T_IDLE;
            end else begin
               next_t.delay_cnt = t.delay_cnt - 32'h1;
            end
         end
         default: begin
            next_t.state = T_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t       <= '0;
         t.state <= T_IDLE;
      end else begin
         t <= next_t;
      end
   end

   // helper: cycles since the last request and the delay it armed
   logic [31:0] since;
   logic [31:0] dly_l;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since <= 32'h0;
         dly_l <= 32'h0;
      end else if (tif.req_done) begin
         since <= 32'h0;
         dly_l <= tif.resp_delay;
      end else if (since != 32'hffffffff) begin
         since <= since + 32'h1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence arm_seq;
      tif.req_done ##1 (t.state == T_WAIT);
   endsequence

   resp_arm_a: assert property (tif.req_done |-> arm_seq) // (R13)
      else $error("response timer not armed by request");
   resp_wait_a: assert property (tif.resp_go |->
      since == ((dly_l == 32'h0) ? 32'h1 : dly_l)) // (R13)
      else $error("response released before its delay");
   limit_off_a: assert property ((tif.limit_ms == 16'h0000) |=> !tif.timeout) // (R21)
      else $error("timeout raised with monitoring off");
   restart_a: assert property (tif.req_done |=> t.ms_count == 16'h0000 && !t.expired) // (R21)
      else $error("interval timer not restarted");

endmodule

// ---- rtl/drive_param_channel.sv ----
// serial drive parameter channel slave with register access over AHB-Lite
`timescale 1ns/100ps
`include "drive_chan_consts.svh"

// Rules this block and the bus master follow
// (R1) identifier 6 reads an array element
// (R2) identifier 7 writes a word array element
// (R3) number is bits 10..0 plus page offset
// (R4) page index high byte, zero below 2000
// (R5) subindex low byte, zero when unindexed
// (R6) read ignores value words three and four
// (R7) word three high half, four low
// (R8) connector: source, drive object, index
// (R9) first words: control, setpoint / status, actual
// (R10) length four or more adds control two
// (R11) character lasts eleven bit times
// (R12) master idles over two characters first
// (R13) response waits for the response delay
// (R14) master keeps character gaps below start delay
// (R15) master watches our response delay
// (R16) request interval over limit raises failure
// (R17) limit guide is 150% of characters
// (R18) control bit 10 clear while running faults
// (R19) page index codes the number offset
// (R20) unprocessable request answers 7 with error
// (R21) interval timer restarts, off at zero
module drive_param_channel
   import drive_chan_pkg::*;
#(
   parameter int MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        rx_word_valid,
   input  wire logic [15:0] rx_word,
   input  wire logic        rx_end,
   input  wire logic        rx_ok,
   input  wire logic        motor_running,
   output logic             resp_start,
   output logic [3:0]       resp_id,
   output logic [15:0]      resp_error,
   output logic [15:0]      first_status_word,
   output logic [15:0]      main_actual_value,
   output logic             telegram_failure_fault,
   output logic             control_request_missing_fault
);

   chan_regs_t  s;
   chan_regs_t  next_s;
   logic [16:0] ofs;
   logic [2:0]  clr;
   logic        commit;
   logic        resp_hsize_unused;
   timer_if     tif();

   // (R19) page index to offset
   function automatic logic [16:0] page_offset(input logic [7:0] page);
      case (page)
         `PAGE_0:     page_offset = {1'b1, `OFFSET_0};
         `PAGE_2000:  page_offset = {1'b1, `OFFSET_2000};
         `PAGE_6000:  page_offset = {1'b1, `OFFSET_6000};
         `PAGE_8000:  page_offset = {1'b1, `OFFSET_8000};
         `PAGE_10000: page_offset = {1'b1, `OFFSET_10000};
         `PAGE_20000: page_offset = {1'b1, `OFFSET_20000};
         `PAGE_30000: page_offset = {1'b1, `OFFSET_30000};
         `PAGE_60000: page_offset = {1'b1, `OFFSET_60000};
         default:     page_offset = 17'h00000;
      endcase
   endfunction

   function automatic logic [31:0] read_reg(input chan_regs_t r, input logic [7:0] a);
      case (a)
         `OFS_CTRL:   read_reg = {28'h0, r.pd_len};
         `OFS_LIMIT:  read_reg = {16'h0, r.limit_ms};
         `OFS_DELAY:  read_reg = r.resp_delay;
         `OFS_STATUS: read_reg = {r.resp_error, 13'h0, r.err, r.missing, r.fail};
         `OFS_REQ:    read_reg = {4'h0, r.subindex, r.req_id, r.full_num};
         `OFS_VALUE:  read_reg = r.value;
         `OFS_CONN:   read_reg = {r.conn_idx, r.conn_obj, r.conn_src};
         `OFS_PD_IN:  read_reg = {r.setpoint, r.ctrl1};
         `OFS_PD_IN2: read_reg = {16'h0, r.ctrl2};
         `OFS_PD_OUT: read_reg = {r.actual_value, r.status_word};
         default:     read_reg = 32'h0;
      endcase
   endfunction

   assign hreadyout                     = s.hreadyout;
   assign hrdata                        = s.hrdata;
   assign hresp                         = 1'b0;
   assign resp_start                    = s.resp_start;
   assign resp_id                       = s.resp_id;
   assign resp_error                    = s.resp_error;
   assign first_status_word             = s.status_word;
   assign main_actual_value             = s.actual_value;
   assign telegram_failure_fault        = s.fail;
   assign control_request_missing_fault = s.missing;
   assign resp_hsize_unused             = |hsize;

   assign tif.limit_ms   = s.limit_ms;
   assign tif.resp_delay = s.resp_delay;
   assign tif.req_done   = s.req_done;

   // a telegram counts only when whole, error free and carries the full channel
   assign commit = rx_end && rx_ok && (s.wcount >= `CHAN_WORDS);
   // (R4) page index high byte
   assign ofs    = page_offset(s.rxw[1][15:8]);
   assign clr    = (s.wr_pend && s.waddr == `OFS_STATUS) ? hwdata[2:0] : 3'h0;

   always_comb begin
      next_s            = s;
      next_s.hreadyout  = 1'b1;
      next_s.resp_start = tif.resp_go;
      next_s.req_done   = 1'b0;
      next_s.wr_pend    = 1'b0;
      next_s.run_meta   = motor_running;
      next_s.run_sync   = s.run_meta;
      if (s.wr_pend) begin
         case (s.waddr)
            `OFS_CTRL:   next_s.pd_len = hwdata[3:0];
            `OFS_LIMIT:  next_s.limit_ms = hwdata[15:0];
            `OFS_DELAY:  next_s.resp_delay = hwdata;
            `OFS_PD_OUT: begin
               next_s.status_word  = hwdata[15:0];
               next_s.actual_value = hwdata[31:16];
            end
            default: begin
            end
         endcase
      end
      // hardware set wins over a software clear in the same cycle
      next_s.fail    = (s.fail & ~clr[0]) | tif.timeout;
      next_s.missing = s.missing & ~clr[1];
      next_s.err     = s.err & ~clr[2];
      // words beyond eight are dropped; the decoder never looks that far
      if (rx_word_valid && s.wcount != `RX_WORDS) begin
         next_s.rxw[s.wcount[2:0]] = rx_word;
         next_s.wcount             = s.wcount + 4'h1;
      end
      if (rx_end) begin
         next_s.wcount = 4'h0;
      end
      if (commit) begin
         next_s.req_done = 1'b1;
         // (R1) identifier field
         next_s.req_id   = s.rxw[0][15:12];
         // (R5) subindex field
         next_s.subindex = s.rxw[1][7:0];
         // (R3) reduced number plus offset
         next_s.full_num = {5'h00, s.rxw[0][10:0]} + ofs[15:0];
         next_s.resp_id  = `RESP_ACK;
         if (!ofs[16]) begin
            // (R20) unknown page index
            next_s.resp_id    = `RESP_ERROR;
            next_s.resp_error = `ERR_BAD_NUMBER;
            next_s.err        = 1'b1;
         end else if (s.rxw[0][15:12] == `AK_READ_ARRAY) begin
            // (R6) value words ignored
            next_s.resp_error = 16'h0000;
         end else if (s.rxw[0][15:12] == `AK_WRITE_ARRAY) begin
            // (R2) word write request
            // (R7) high then low word
            next_s.value    = {s.rxw[2], s.rxw[3]};
            // (R8) connector fields
            next_s.conn_src = s.rxw[2];
            next_s.conn_obj = s.rxw[3][15:10];
            next_s.conn_idx = s.rxw[3][9:0];
            next_s.resp_error = 16'h0000;
         end else begin
            // (R20) unsupported identifier
            next_s.resp_id    = `RESP_ERROR;
            next_s.resp_error = `ERR_NOT_SUPPORTED;
            next_s.err        = 1'b1;
         end
         // (R9) first process data words
         if (s.pd_len >= 4'h1 && s.wcount >= 4'h5) begin
            next_s.ctrl1 = s.rxw[4];
            // (R18) control request bit
            if (!s.rxw[4][`CTRL1_REQ_BIT] && s.run_sync) begin
               next_s.missing = 1'b1;
            end
         end
         if (s.pd_len >= 4'h2 && s.wcount >= 4'h6) begin
            next_s.setpoint = s.rxw[5];
         end
         // (R10) second control word
         if (s.pd_len >= `PD_CTRL2_MIN_LEN && s.wcount >= `RX_WORDS) begin
            next_s.ctrl2 = s.rxw[7];
         end
      end
      // read data is taken from the next state so a write just before is seen
      if (hsel && hready && htrans[1]) begin
         next_s.wr_pend = hwrite && (haddr[31:8] == 24'h0);
         next_s.waddr   = haddr[7:0];
         if (!hwrite) begin
            next_s.hrdata = (haddr[31:8] == 24'h0) ? read_reg(next_s, haddr[7:0]) : 32'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s            <= '0;
         s.hreadyout  <= 1'b1;
         s.pd_len     <= `PD_LEN_RST;
         // (R17) limit default
         s.limit_ms   <= `LIMIT_RST;
         // (R11) delay from character time
         s.resp_delay <= `RESP_DELAY_RST;
      end else begin
         s <= next_s;
      end
   end

   request_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (tif.timer)
   );

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   read_decode_a: assert property (commit && s.rxw[0][15:12] == `AK_READ_ARRAY
      && page_offset(s.rxw[1][15:8]) != 17'h0 |=> s.req_id == `AK_READ_ARRAY
      && s.resp_id == `RESP_ACK) // (R1)
      else $error("read request not decoded");
   write_value_a: assert property (commit && s.rxw[0][15:12] == `AK_WRITE_ARRAY
      && ofs[16] |=> s.value == {$past(s.rxw[2]), $past(s.rxw[3])}) // (R2)
      else $error("write value not taken high then low");
   full_number_a: assert property (commit && s.rxw[1][15:8] == `PAGE_6000
      |=> s.full_num == $past({5'h00, s.rxw[0][10:0]}) + `OFFSET_6000) // (R3)
      else $error("page offset not added");
   page_zero_a: assert property (commit && s.rxw[1][15:8] == `PAGE_0
      |=> s.full_num == $past({5'h00, s.rxw[0][10:0]})) // (R4)
      else $error("page zero changed the number");
   subindex_a: assert property (commit |=> s.subindex == $past(s.rxw[1][7:0])) // (R5)
      else $error("subindex not taken from low byte");
   read_ignore_a: assert property (commit && s.rxw[0][15:12] == `AK_READ_ARRAY
      |=> $stable(s.value) && $stable(s.conn_src)) // (R6)
      else $error("read request changed value");
   connector_a: assert property (commit && s.rxw[0][15:12] == `AK_WRITE_ARRAY && ofs[16]
      |=> s.conn_obj == $past(s.rxw[3][15:10]) && s.conn_idx == $past(s.rxw[3][9:0])) // (R8)
      else $error("connector fields misplaced");
   ctrl2_gate_a: assert property (s.pd_len < `PD_CTRL2_MIN_LEN |=> $stable(s.ctrl2)) // (R10)
      else $error("second control word taken at short length");
   bad_request_a: assert property (commit && ofs[16] && s.rxw[0][15:12] != `AK_READ_ARRAY
      && s.rxw[0][15:12] != `AK_WRITE_ARRAY |=> s.resp_id == `RESP_ERROR
      && s.resp_error == `ERR_NOT_SUPPORTED) // (R20)
      else $error("unsupported request not refused");
   missing_ctrl_a: assert property (commit && s.pd_len != 4'h0 && s.wcount >= 4'h5
      && !s.rxw[4][`CTRL1_REQ_BIT] && s.run_sync |=> s.missing ##1 control_request_missing_fault) // (R18)
      else $error("missing control request not flagged");
   fail_fault_a: assert property (tif.timeout |=> s.fail) // (R16)
      else $error("telegram failure not flagged");

endmodule

// ---- dv/fieldbus_master_model.sv ----
// bus master model feeding request telegram words to the channel slave
`timescale 1ns/100ps

module fieldbus_master_model #(
   parameter int CHAR_CYC = 4
) (
   input  wire logic   hclk,
   output logic        rx_word_valid,
   output logic [15:0] rx_word,
   output logic        rx_end,
   output logic        rx_ok
);
   initial begin
      rx_word_valid = 1'b0;
      rx_word       = 16'h0000;
      rx_end        = 1'b0;
      rx_ok         = 1'b0;
   end

   task automatic send_telegram(input logic [7:0][15:0] w, input int n, input logic ok);
      // read requests carry zero value words
      if (w[0][15:12] == 4'h6) begin
         w[2] = 16'h0000;
         w[3] = 16'h0000;
      end
      repeat (2 * CHAR_CYC + 1) @(posedge hclk);
      for (int i = 0; i < n; i++) begin
         rx_word_valid <= 1'b1;
         rx_word       <= w[i];
         @(posedge hclk);
         rx_word_valid <= 1'b0;
         // inverse of last word so stale data never looks valid
         rx_word       <= ~w[i];
         repeat (CHAR_CYC - 1) @(posedge hclk);
      end
      rx_end <= 1'b1;
      rx_ok  <= ok;
      @(posedge hclk);
      rx_end <= 1'b0;
      rx_ok  <= 1'b0;
   endtask
endmodule

// ---- dv/drive_param_channel_test.sv ----
// self-checking bench of the drive parameter channel slave
`timescale 1ns/100ps
`include "drive_chan_consts.svh"
`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); \
   end \
end

module drive_param_channel_test;
   localparam int MS_CYC = 50;
   localparam int DLY    = 7;
   localparam logic [7:0]  PG [8]  = '{`PAGE_0, `PAGE_2000, `PAGE_6000, `PAGE_8000,
                                       `PAGE_10000, `PAGE_20000, `PAGE_30000, `PAGE_60000};
   localparam logic [15:0] OFS [8] = '{`OFFSET_0, `OFFSET_2000, `OFFSET_6000, `OFFSET_8000,
                                       `OFFSET_10000, `OFFSET_20000, `OFFSET_30000, `OFFSET_60000};
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        rx_word_valid;
   logic [15:0] rx_word;
   logic        rx_end;
   logic        rx_ok;
   logic        motor_running;
   logic        resp_start;
   logic [3:0]  resp_id;
   logic [15:0] resp_error;
   logic [15:0] first_status_word;
   logic [15:0] main_actual_value;
   logic        telegram_failure_fault;
   logic        control_request_missing_fault;
   int          miscompares;
   int          n_checks;
   int          cycles;

   assign hready = hreadyout;

   drive_param_channel #(.MS_CYCLES(MS_CYC)) dut_u (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hrdata, .hresp, .rx_word_valid, .rx_word, .rx_end, .rx_ok,
      .motor_running, .resp_start, .resp_id, .resp_error, .first_status_word,
      .main_actual_value, .telegram_failure_fault, .control_request_missing_fault
   );

   fieldbus_master_model #(.CHAR_CYC(4)) master_u (
      .hclk, .rx_word_valid, .rx_word, .rx_end, .rx_ok
   );

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic finish_test();
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // hang guard, the whole run needs under two thousand cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           output logic [31:0] r);
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb_xfer(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb_xfer(1'b0, a, 32'h0, r);
      `CHK(r, e)
   endtask

   function automatic logic [7:0][15:0] mk(input logic [3:0] id, input logic [10:0] reduced_param_number,
         input logic [7:0] pg, input logic [7:0] sub, input logic [15:0] hi,
         input logic [15:0] lo, input logic [15:0] c1);
      mk = {16'h5678, 16'h0000, 16'h1234, c1, lo, hi, pg, sub, id, 1'b0, reduced_param_number};
   endfunction

   // send one telegram, then count cycles until the response may start
   task automatic tele(input logic [7:0][15:0] w, input logic ok, output int k);
      master_u.send_telegram(w, 8, ok);
      k = 0;
      for (int i = 1; i <= 40 && k == 0; i++) begin
         // look mid-cycle, away from the edge that launches the pulse
         @(negedge hclk);
         if (resp_start === 1'b1) k = i;
      end
      @(posedge hclk);
   endtask

   initial begin
      int k;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      motor_running = 1'b0;
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(`OFS_CTRL, 32'h00000004);
      rd_chk(`OFS_LIMIT, 32'h00000064);
      rd_chk(`OFS_DELAY, 32'h00029f7c);
      rd_chk(`OFS_STATUS, 32'h0);
      rd_chk(32'h00000100, 32'h0);
      `CHK(hresp, 1'b0)
      wr(`OFS_LIMIT, 32'h0);
      wr(`OFS_DELAY, DLY);
      wr(`OFS_PD_OUT, 32'hbeef0a5c);
      wr(`OFS_CTRL, 32'h00000003);
      rd_chk(`OFS_CTRL, 32'h00000003);
      repeat (2) @(posedge hclk);
      `CHK(first_status_word, 16'h0a5c)
      `CHK(main_actual_value, 16'hbeef)
      tele(mk(4'h6, 11'd1841, `PAGE_6000, 8'h02, 16'h0, 16'h0, 16'h0400), 1'b1, k);
      `CHK(k, DLY + 3)
      `CHK(k > 2 * 4 + 1, 1'b1)
      `CHK(resp_id, `RESP_ACK)
      rd_chk(`OFS_REQ, 32'h00261ea1);
      rd_chk(`OFS_PD_IN, 32'h12340400);
      rd_chk(`OFS_PD_IN2, 32'h00000000);
      wr(`OFS_CTRL, 32'h00000004);
      tele(mk(4'h7, 11'h4ba, `PAGE_0, 8'h00, 16'h0, 16'h001a, 16'h0400), 1'b1, k);
      rd_chk(`OFS_REQ, 32'h000704ba);
      rd_chk(`OFS_VALUE, 32'h0000001a);
      rd_chk(`OFS_PD_IN2, 32'h00005678);
      tele(mk(4'h7, 11'h348, `PAGE_0, 8'h01, 16'h02d2, 16'hfc02, 16'h0400), 1'b1, k);
      rd_chk(`OFS_CONN, 32'h00bf02d2);
      rd_chk(`OFS_VALUE, 32'h02d2fc02);
      for (int i = 0; i < 8; i++) begin
         tele(mk(4'h6, 11'd5, PG[i], 8'h00, 16'h0, 16'h0, 16'h0400), 1'b1, k);
         rd_chk(`OFS_REQ, {12'h000, 4'h6, 16'(OFS[i] + 16'd5)});
      end
      tele(mk(4'h6, 11'd9, `PAGE_0, 8'h00, 16'h0, 16'h0, 16'h0400), 1'b0, k);
      `CHK(k, 0)
      rd_chk(`OFS_REQ, 32'h0006ea65);
      tele(mk(4'h6, 11'd5, 8'h11, 8'h00, 16'h0, 16'h0, 16'h0400), 1'b1, k);
      `CHK(resp_id, `RESP_ERROR)
      `CHK(resp_error, `ERR_BAD_NUMBER)
      tele(mk(4'h3, 11'd5, `PAGE_0, 8'h00, 16'h0, 16'h0, 16'h0400), 1'b1, k);
      `CHK(resp_error, `ERR_NOT_SUPPORTED)
      rd_chk(`OFS_STATUS, 32'h006a0004);
      wr(`OFS_STATUS, 32'h00000004);
      rd_chk(`OFS_STATUS, 32'h006a0000);
      repeat (300) @(posedge hclk);
      `CHK(telegram_failure_fault, 1'b0)
      motor_running <= 1'b1;
      tele(mk(4'h6, 11'd1, `PAGE_0, 8'h00, 16'h0, 16'h0, 16'h0400), 1'b1, k);
      wr(`OFS_LIMIT, 32'h00000003);
      repeat (3) tele(mk(4'h6, 11'd1, `PAGE_0, 8'h00, 16'h0, 16'h0, 16'h0400), 1'b1, k);
      `CHK(telegram_failure_fault, 1'b0)
      `CHK(control_request_missing_fault, 1'b0)
      repeat (300) @(posedge hclk);
      `CHK(telegram_failure_fault, 1'b1)
      tele(mk(4'h6, 11'd1, `PAGE_0, 8'h00, 16'h0, 16'h0, 16'h0000), 1'b1, k);
      `CHK(control_request_missing_fault, 1'b1)
      rd_chk(`OFS_STATUS, 32'h00000003);
      finish_test();
   end
endmodule
